/* hdl/fsc_core.sv */
// Synthesizer control: registers, seeding, resets and power-down
`timescale 1ns/1ps
module fsc_core #(
  parameter int POR_CYCLES = fsc_pkg::POR_CYCLES
) (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire logic               chip_enable_input,
  input  wire logic               protocol_sel_in,
  input  wire logic               protocol_decided,
  input  wire fsc_pkg::fsc_write_s wr,
  input  wire logic [5:0]         rd_addr,
  output logic      [23:0]        rd_data,
  output logic                    por_done,
  output logic                    protocol_sel,
  output logic                    powered,
  output logic      [5:0]         keep_on,
  output logic      [18:0]        int_ratio,
  output logic      [23:0]        frac_ratio,
  output logic      [13:0]        exact_divisor,
  output logic      [23:0]        osc_word,
  output logic                    osc_write,
  output logic      [23:0]        mod_phase,
  output logic                    mod_carry
);
  logic [1:0]  ce_sync_reg;
  logic        por_reg;
  logic [13:0] por_cnt_reg;
  logic        soft_rst;
  logic        syn_rst;
  logic [23:0] chipen_reg;
  logic [18:0] int_reg;
  logic [23:0] frac_reg;
  logic [23:0] osc_reg;
  logic [23:0] seed_reg;
  logic [13:0] exact_reg;
  logic        frac_new_reg;
  logic        enable_next;
  logic        run;
  logic [23:0] seed_phase;
  logic [23:0] phase_w;
  logic        carry_w;
  logic [18:0] int_next;
  logic        proto_reg;
  logic        proto_held_reg;
  fsc_pkg::fsc_power_e state_reg;

  // Chip enable pin synchroniser
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ce_sync_reg <= 2'b00;
    end else begin
      ce_sync_reg <= {ce_sync_reg[0], chip_enable_input};
    end
  end

  // Power-on reset interval counter; rst models supply application
  always_ff @(posedge core_clk) begin
    if (rst) begin
      por_cnt_reg <= 14'h0000;
      por_reg     <= 1'b1;
    end else if (por_reg) begin
      if (por_cnt_reg == 14'(POR_CYCLES - 1)) begin
        por_reg <= 1'b0;
      end
      por_cnt_reg <= por_cnt_reg + 14'h0001;
    end
  end

  // Soft reset on completed write to register 0 with the reset bit
  assign soft_rst = wr.valid && wr.addr == fsc_pkg::ADDR_VERSION
                    && wr.data[fsc_pkg::SOFT_RESET_BIT];
  assign syn_rst  = por_reg || soft_rst;

  // Protocol selection latched once after power-up, untouched by soft reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      proto_reg      <= 1'b0;
      proto_held_reg <= 1'b0;
    end else if (!proto_held_reg && protocol_decided) begin
      proto_reg      <= protocol_sel_in;
      proto_held_reg <= 1'b1;
    end
  end

  // Integer ratio clamped into its legal span
  always_comb begin
    int_next = wr.data[18:0];
    if (wr.data[18:0] < fsc_pkg::INTEGER_MIN) begin
      int_next = fsc_pkg::INTEGER_MIN;
    end else if (wr.data[18:0] > fsc_pkg::INTEGER_MAX) begin
      int_next = fsc_pkg::INTEGER_MAX;
    end
  end

  // Synthesizer registers; writes accepted in run and power-down, dropped while power-on reset holds
  always_ff @(posedge core_clk) begin
    if (rst || syn_rst) begin
      chipen_reg <= fsc_pkg::CHIPEN_RESET;
      int_reg    <= fsc_pkg::INTEGER_RESET;
      frac_reg   <= fsc_pkg::FRAC_RESET;
      seed_reg   <= fsc_pkg::SEED_RESET;
      exact_reg  <= fsc_pkg::EXACT_RESET;
    end else if (wr.valid) begin
      unique case (wr.addr)
        fsc_pkg::ADDR_CHIPEN: chipen_reg <= wr.data;
        fsc_pkg::ADDR_INTEGER: int_reg <= int_next;
        fsc_pkg::ADDR_FRAC: frac_reg <= wr.data;
        fsc_pkg::ADDR_SEED: seed_reg <= wr.data;
        fsc_pkg::ADDR_EXACT: exact_reg <= wr.data[13:0];
        default: ;
      endcase
    end
  end

  // Oscillator register: only power removal resets it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      osc_reg   <= fsc_pkg::OSC_RESET;
      osc_write <= 1'b0;
    end else begin
      osc_write <= wr.valid && wr.addr == fsc_pkg::ADDR_OSC;
      if (wr.valid && wr.addr == fsc_pkg::ADDR_OSC) begin
        osc_reg <= wr.data;
      end
    end
  end

  // New fractional word takes effect the cycle after its write
  always_ff @(posedge core_clk) begin
    if (rst || syn_rst) begin
      frac_new_reg <= 1'b0;
    end else begin
      frac_new_reg <= wr.valid && wr.addr == fsc_pkg::ADDR_FRAC;
    end
  end

  // Power enable from pin or software bit
  always_comb begin
    if (chipen_reg[fsc_pkg::PIN_SELECT_BIT]) begin
      enable_next = ce_sync_reg[1];
    end else begin
      enable_next = chipen_reg[fsc_pkg::SW_ENABLE_BIT];
    end
  end

  // Power state machine
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= fsc_pkg::FSC_POR;
    end else begin
      unique case (state_reg)
        fsc_pkg::FSC_POR: begin
          if (!por_reg) begin
            state_reg <= enable_next ? fsc_pkg::FSC_RUN : fsc_pkg::FSC_PWRDN;
          end
        end
        fsc_pkg::FSC_RUN: begin
          if (!enable_next) begin
            state_reg <= fsc_pkg::FSC_PWRDN;
          end
        end
        fsc_pkg::FSC_PWRDN: begin
          if (enable_next) begin
            state_reg <= fsc_pkg::FSC_RUN;
          end
        end
        default: state_reg <= fsc_pkg::FSC_POR;
      endcase
    end
  end

  assign run = state_reg == fsc_pkg::FSC_RUN;

  // Seed phase selection
  always_comb begin
    unique case (seed_reg[1:0])
      2'h0: seed_phase = fsc_pkg::SEED_PHASE0;
      2'h1: seed_phase = fsc_pkg::SEED_PHASE1;
      2'h2: seed_phase = fsc_pkg::SEED_PHASE2;
      default: seed_phase = fsc_pkg::SEED_PHASE3;
    endcase
  end

  // Accumulator; reseed only with auto reseed, otherwise carry on
  fsc_accum u_accum (
    .core_clk   (core_clk),
    .rst        (rst || syn_rst),
    .run        (run),
    .load_seed  (frac_new_reg && seed_reg[fsc_pkg::AUTO_RESEED_BIT]),
    .seed_phase (seed_phase),
    .frac_word  (frac_reg),
    .phase      (phase_w),
    .carry      (carry_w)
  );

  // Registered outputs
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_data       <= 24'h000000;
      por_done      <= 1'b0;
      protocol_sel  <= 1'b0;
      powered       <= 1'b0;
      keep_on       <= 6'h00;
      int_ratio     <= fsc_pkg::INTEGER_RESET;
      frac_ratio    <= fsc_pkg::FRAC_RESET;
      exact_divisor <= fsc_pkg::EXACT_RESET;
      osc_word      <= fsc_pkg::OSC_RESET;
      mod_phase     <= 24'h000000;
      mod_carry     <= 1'b0;
    end else begin
      unique case (rd_addr)
        fsc_pkg::ADDR_VERSION: rd_data <= fsc_pkg::VERSION_INFO;
        fsc_pkg::ADDR_CHIPEN: rd_data <= chipen_reg;
        fsc_pkg::ADDR_INTEGER: rd_data <= {5'h00, int_reg};
        fsc_pkg::ADDR_FRAC: rd_data <= frac_reg;
        fsc_pkg::ADDR_SEED: rd_data <= seed_reg;
        fsc_pkg::ADDR_EXACT: rd_data <= {10'h000, exact_reg};
        default: rd_data <= 24'h000000;
      endcase
      por_done      <= !por_reg;
      protocol_sel  <= proto_reg;
      powered       <= run;
      keep_on       <= run ? 6'h3F
                       : chipen_reg[fsc_pkg::KEEP_ON_LSB +: fsc_pkg::KEEP_ON_COUNT];
      int_ratio     <= int_reg;
      frac_ratio    <= frac_reg;
      exact_divisor <= exact_reg;
      osc_word      <= osc_reg;
      mod_phase     <= phase_w;
      mod_carry     <= carry_w;
    end
  end

  // Soft reset returns the integer ratio to default two cycles later
  soft_reset_int_a: assert property (@(posedge core_clk) disable iff (rst)
    soft_rst |-> ##2 int_ratio == fsc_pkg::INTEGER_RESET)
    else $error("soft reset did not restore integer ratio");

  // The reset-carrying write is not retained in the chip enable register
  soft_reset_drop_a: assert property (@(posedge core_clk) disable iff (rst)
    soft_rst |=> chipen_reg == fsc_pkg::CHIPEN_RESET)
    else $error("soft reset write was retained");

  // Oscillator word survives soft reset
  osc_keep_a: assert property (@(posedge core_clk) disable iff (rst)
    soft_rst && !(wr.addr == fsc_pkg::ADDR_OSC) |=> $stable(osc_reg))
    else $error("oscillator register disturbed by soft reset");

  // Protocol selection unchanged by soft reset
  proto_keep_a: assert property (@(posedge core_clk) disable iff (rst)
    proto_held_reg |=> $stable(proto_reg))
    else $error("protocol selection changed");

  // Auto reseed loads selected phase
  auto_reseed_a: assert property (@(posedge core_clk) disable iff (rst)
    frac_new_reg && seed_reg[fsc_pkg::AUTO_RESEED_BIT] && !syn_rst
    |=> phase_w == $past(seed_phase))
    else $error("auto reseed did not load seed");

  // Without reseed accumulation continues
  no_reseed_a: assert property (@(posedge core_clk) disable iff (rst)
    run && !seed_reg[fsc_pkg::AUTO_RESEED_BIT] && !syn_rst
    |=> phase_w == 24'($past(phase_w) + $past(frac_reg)))
    else $error("accumulator did not continue");

  // Software enable governs power when pin select is clear
  sw_enable_a: assert property (@(posedge core_clk) disable iff (rst)
    state_reg != fsc_pkg::FSC_POR && !chipen_reg[fsc_pkg::PIN_SELECT_BIT]
    && !chipen_reg[fsc_pkg::SW_ENABLE_BIT] && !syn_rst |=> ##1 !powered)
    else $error("software power-down ignored");

  // Power-down stops the accumulator
  pwrdn_clock_a: assert property (@(posedge core_clk) disable iff (rst)
    !run && !frac_new_reg && !syn_rst |=> $stable(phase_w))
    else $error("accumulator ran in power-down");

  // Integer ratio stays in range
  int_range_a: assert property (@(posedge core_clk) disable iff (rst)
    int_reg >= fsc_pkg::INTEGER_MIN && int_reg <= fsc_pkg::INTEGER_MAX)
    else $error("integer ratio out of range");

  // Power-on reset ends exactly at the interval
  por_len_a: assert property (@(posedge core_clk) disable iff (rst)
    por_reg && por_cnt_reg == 14'(POR_CYCLES - 1) |=> !por_reg ##1 por_done)
    else $error("power-on reset interval wrong");
endmodule

/* pkg/fsc_pkg.sv */
// Package: register map, field positions, reset values and timing for the synthesizer control
package fsc_pkg;
  // Register addresses (6-bit serial address space)
  localparam logic [5:0] ADDR_VERSION   = 6'h00;
  localparam logic [5:0] ADDR_CHIPEN    = 6'h01;
  localparam logic [5:0] ADDR_INTEGER   = 6'h03;
  localparam logic [5:0] ADDR_FRAC      = 6'h04;
  localparam logic [5:0] ADDR_OSC       = 6'h05;
  localparam logic [5:0] ADDR_SEED      = 6'h06;
  localparam logic [5:0] ADDR_EXACT     = 6'h0C;

  // Field positions
  localparam int SOFT_RESET_BIT   = 5;
  localparam int PIN_SELECT_BIT   = 0;
  localparam int SW_ENABLE_BIT    = 1;
  localparam int KEEP_ON_LSB      = 2;
  localparam int KEEP_ON_COUNT    = 6;
  localparam int AUTO_RESEED_BIT  = 8;

  // Reset values
  localparam logic [23:0] CHIPEN_RESET  = 24'h000001;
  localparam logic [18:0] INTEGER_RESET = 19'h00014;
  localparam logic [23:0] FRAC_RESET    = 24'h000000;
  localparam logic [23:0] OSC_RESET     = 24'h000000;
  localparam logic [23:0] SEED_RESET    = 24'h000000;
  localparam logic [13:0] EXACT_RESET   = 14'h0000;
  // Version value is arbitrary
  localparam logic [23:0] VERSION_INFO  = 24'h00A5C3;

  // Integer ratio limits
  localparam logic [18:0] INTEGER_MIN   = 19'h00014;
  localparam logic [18:0] INTEGER_MAX   = 19'h7FFFC;

  // Four preset start phases for the phase accumulator (seed 0..3)
  localparam logic [23:0] SEED_PHASE0   = 24'h000000;
  localparam logic [23:0] SEED_PHASE1   = 24'h800000;
  localparam logic [23:0] SEED_PHASE2   = 24'hB29D2D;
  localparam logic [23:0] SEED_PHASE3   = 24'h50F44D;

  // Power-on reset delay
  localparam int POR_TIME_US   = 250;
  localparam int CLK_MHZ       = 50;
  localparam int POR_CYCLES    = POR_TIME_US * CLK_MHZ;

  // Write strobe from the serial port
  typedef struct packed {
    logic        valid;
    logic [5:0]  addr;
    logic [23:0] data;
  } fsc_write_s;

  // Power state of the core
  typedef enum logic [1:0] {
    FSC_POR,
    FSC_RUN,
    FSC_PWRDN
  } fsc_power_e;
endpackage

/* hdl/fsc_accum.sv */
// Fractional modulator phase accumulator with seed reload
`timescale 1ns/1ps
module fsc_accum (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        run,
  input  wire logic        load_seed,
  input  wire logic [23:0] seed_phase,
  input  wire logic [23:0] frac_word,
  output logic      [23:0] phase,
  output logic             carry
);
  logic [24:0] sum_next;

  // Next sum including the modulator carry
  always_comb begin
    sum_next = {1'b0, phase} + {1'b0, frac_word};
  end

  // Seed reload has priority over accumulation; clocks stop when not running
  always_ff @(posedge core_clk) begin
    if (rst) begin
      phase <= 24'h000000;
      carry <= 1'b0;
    end else if (load_seed) begin
      phase <= seed_phase;
      carry <= 1'b0;
    end else if (run) begin
      phase <= sum_next[23:0];
      carry <= sum_next[24];
    end else begin
      carry <= 1'b0;
    end
  end
endmodule

/* testbench/fsc_host_model.sv */
// Host model: register writes and reads through the strobe port
`timescale 1ns/1ps
module fsc_host_model (
  input  wire logic          core_clk,
  output fsc_pkg::fsc_write_s wr,
  output logic [5:0]         rd_addr,
  input  wire logic [23:0]   rd_data
);
  initial begin
    wr = '0;
    rd_addr = 6'h3F;
  end
  // One write strobe; released fields carry inverted junk
  task automatic write_reg(input logic [5:0] a, input logic [23:0] d);
    @(posedge core_clk);
    wr <= '{valid: 1'b1, addr: a, data: d};
    @(posedge core_clk);
    wr <= '{valid: 1'b0, addr: ~a, data: ~d};
  endtask
  // Registered read: data lands one cycle after the address
  task automatic read_reg(input logic [5:0] a, output logic [23:0] d);
    @(posedge core_clk);
    rd_addr <= a;
    repeat (2) @(posedge core_clk);
    #1 d = rd_data;
  endtask
  // Channel word, frequencies in kHz, rounded up
  function automatic logic [23:0] chan_frac(input longint f, fn, fpd);
    return 24'((((f - fn) << 24) + fpd - 1) / fpd);
  endfunction
endmodule

/* testbench/testbench.sv */
// Self-checking bench for the synthesizer control core
`timescale 1ns/1ps
module testbench;
  localparam int POR = 20;
  logic                core_clk;
  logic                rst;
  logic                chip_enable_input;
  logic                protocol_sel_in;
  logic                protocol_decided;
  fsc_pkg::fsc_write_s wr;
  logic [5:0]          rd_addr;
  logic [23:0]         rd_data;
  logic                por_done;
  logic                protocol_sel;
  logic                powered;
  logic [5:0]          keep_on;
  logic [18:0]         int_ratio;
  logic [23:0]         frac_ratio;
  logic [13:0]         exact_divisor;
  logic [23:0]         osc_word;
  logic                osc_write;
  logic [23:0]         mod_phase;
  logic                mod_carry;
  logic [23:0]         m [0:63];
  logic [23:0]         sp [4];
  logic [5:0]          al [7];
  int                  err_count = 0;
  int                  n_checks = 0;
  int                  osc_cnt = 0;
  int                  osc_exp = 0;
  int                  cyc = 0;

  fsc_core #(.POR_CYCLES(POR)) i_dut (.core_clk, .rst, .chip_enable_input, .protocol_sel_in,
    .protocol_decided, .wr, .rd_addr, .rd_data, .por_done, .protocol_sel, .powered, .keep_on,
    .int_ratio, .frac_ratio, .exact_divisor, .osc_word, .osc_write, .mod_phase, .mod_carry);
  fsc_host_model i_host (.core_clk, .wr, .rd_addr, .rd_data);

  // Clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (osc_write === 1'b1) osc_cnt++;
    if (cyc == 5000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Reference register file defaults
  function automatic void mreset(input bit por);
    foreach (m[i]) if (por || i != 5) m[i] = 24'h000000;
    m[1] = fsc_pkg::CHIPEN_RESET;
    m[3] = {5'h00, fsc_pkg::INTEGER_RESET};
  endfunction

  // Write through the host and update the reference
  task automatic w(input logic [5:0] a, input logic [23:0] d);
    i_host.write_reg(a, d);
    case (a)
      6'h00: if (d[5]) mreset(1'b0);
      6'h03: m[3] = (d[18:0] < 19'h00014) ? 24'h000014 :
                    (d[18:0] > 19'h7FFFC) ? 24'h07FFFC : {5'h00, d[18:0]};
      6'h01, 6'h04, 6'h05, 6'h06: m[a] = d;
      6'h0C: m[a] = {10'h000, d[13:0]};
      default: ;
    endcase
    if (a == 6'h05) osc_exp++;
    repeat (4) @(posedge core_clk);
    #1;
  endtask

  // Read every mapped register except the oscillator register, plus one hole
  task automatic rall();
    logic [23:0] d;
    foreach (al[i]) begin
      i_host.read_reg(al[i], d);
      chk("register", (al[i] == 6'h00) ? fsc_pkg::VERSION_INFO : m[al[i]], d);
    end
  endtask

  // Supply cycle with a write attempted during the reset interval
  task automatic do_reset();
    int n;
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    mreset(1'b1);
    i_host.write_reg(6'h03, 24'h000064);
    n = 2;
    while (por_done !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk("reset time", 24'(n >= POR && n <= POR + 4), 24'h000001);
  endtask

  initial begin
    logic [23:0] f;
    logic [23:0] g;
    logic [23:0] p;
    bit          hit;
    bit          bad;
    void'($urandom(61325));
    rst = 1'b1;
    chip_enable_input = 1'b1;
    protocol_sel_in = 1'b1;
    protocol_decided = 1'b0;
    sp = '{fsc_pkg::SEED_PHASE0, fsc_pkg::SEED_PHASE1, fsc_pkg::SEED_PHASE2,
           fsc_pkg::SEED_PHASE3};
    al = '{6'h00, 6'h01, 6'h03, 6'h04, 6'h06, 6'h0C, 6'h02};
    do_reset();
    @(posedge core_clk);
    protocol_decided <= 1'b1;
    w(6'h00, 24'h000020);
    @(posedge core_clk);
    protocol_sel_in <= 1'b0;
    rall();
    w(6'h02, 24'h123456);
    rall();
    $display("test reset done");
    // Integer limits
    w(6'h03, 24'h000005);
    chk("int", m[3], {5'h00, int_ratio});
    w(6'h03, 24'hFFFFFF);
    chk("int", m[3], {5'h00, int_ratio});
    $display("test limits done");
    // Channel plan: 100 kHz spacing above 2800.2 MHz, 61.44 MHz detector
    w(6'h03, 24'd45);
    w(6'h0C, 24'(61440 / 20));
    chk("frac", 24'h938000, i_host.chan_frac(2800200, 45 * 61440, 61440));
    for (int i = 0; i < 4; i++) begin
      f = i_host.chan_frac(2800200 + 100 * $urandom_range(0, 259), 45 * 61440, 61440);
      w(6'h04, f);
      chk("frac", m[4], frac_ratio);
      chk("int", 24'd45, {5'h00, int_ratio});
      chk("exact", 24'h000C00, {10'h000, exact_divisor});
    end
    $display("test channels done");
    // Every seed with automatic reseed
    for (int s = 0; s < 4; s++) begin
      w(6'h06, 24'h000100 | 24'(s));
      f = 24'($urandom);
      m[4] = f;
      i_host.write_reg(6'h04, f);
      hit = 1'b0;
      for (int c = 0; c < 8 && !hit; c++) begin
        @(posedge core_clk);
        #1 hit = (mod_phase === sp[s]);
      end
      chk("reseed", 24'(hit), 24'h000001);
      @(posedge core_clk);
      #1 chk("accum", sp[s] + f, mod_phase);
      chk("carry", 24'((25'(sp[s]) + 25'(f)) >> 24), {23'h0, mod_carry});
    end
    // Without reseed each step adds the old or the new word
    w(6'h06, 24'h000001);
    g = m[4];
    f = 24'($urandom);
    m[4] = f;
    i_host.write_reg(6'h04, f);
    #1 p = mod_phase;
    bad = 1'b0;
    repeat (8) begin
      @(posedge core_clk);
      #1 bad |= ((mod_phase - p) !== g) && ((mod_phase - p) !== f);
      p = mod_phase;
    end
    chk("no reseed", 24'(bad), 24'h000000);
    $display("test seed done");
    // Power-down by pin, keep-on bits, software control
    w(6'h05, 24'h000000);
    w(6'h01, 24'h0000A9);
    @(posedge core_clk);
    chip_enable_input <= 1'b0;
    repeat (6) @(posedge core_clk);
    #1 chk("powered", 24'h000000, {23'h0, powered});
    chk("keep", 24'h00002A, {18'h0, keep_on});
    p = mod_phase;
    repeat (4) @(posedge core_clk);
    #1 chk("frozen", p, mod_phase);
    w(6'h03, 24'h000064);
    rall();
    w(6'h01, 24'h000002);
    chk("powered", 24'h000001, {23'h0, powered});
    @(posedge core_clk);
    chip_enable_input <= 1'b1;
    w(6'h01, 24'h000000);
    chk("powered", 24'h000000, {23'h0, powered});
    w(6'h01, 24'h000001);
    chk("keep", 24'h00003F, {18'h0, keep_on});
    $display("test power done");
    // Buffer silencing sequence, then soft reset
    w(6'h05, 24'h002A98);
    w(6'h05, 24'h000D88);
    w(6'h06, 24'h000102);
    w(6'h0C, 24'h000C00);
    w(6'h00, 24'h000010);
    rall();
    w(6'h00, 24'h000020);
    rall();
    chk("osc", 24'h000D88, osc_word);
    chk("osc pulses", 24'(osc_exp), 24'(osc_cnt));
    chk("protocol", 24'h000001, {23'h0, protocol_sel});
    $display("test soft reset done");
    @(posedge core_clk);
    do_reset();
    rall();
    chk("osc", 24'h000000, osc_word);
    chk("protocol", 24'h000000, {23'h0, protocol_sel});
    $display("test supply cycle done");
    give_verdict();
  end
endmodule
